// >>> core/tgsp_map.svh
// Purpose: Register offsets, field positions and reset values of the timer gate block
// Assumes: Word-indexed register port with 4-bit address
// Notes:   Definitions only
`ifndef TGSP_MAP_SVH
`define TGSP_MAP_SVH

`define TGSP_ADDR_W        4
`define TGSP_DATA_W        16
`define TGSP_OFF_CTRL      4'h0
`define TGSP_OFF_COUNT     4'h1
`define TGSP_OFF_IRQ_STAT  4'h2
`define TGSP_OFF_IRQ_MASK  4'h3
`define TGSP_BIT_GATE_EN   0
`define TGSP_BIT_TOGGLE    1
`define TGSP_BIT_SPM       2
`define TGSP_BIT_GO        3
`define TGSP_BIT_POL       4
`define TGSP_BIT_TMR_ON    5
`define TGSP_BIT_LEVEL     6
`define TGSP_BIT_EV_DONE   0
`define TGSP_BIT_EV_OVF    1
`define TGSP_IRQ_W         2
`define TGSP_CTRL_RST      16'h0000
`define TGSP_COUNT_RST     16'h0000

`endif

// >>> core/tgsp_pkg.sv
// Purpose: Types shared by the timer gate block
// Assumes: Included map header for widths
// Notes:   Types only
`include "tgsp_map.svh"
package tgsp_pkg;
	typedef enum logic [1:0] {
		TGSP_IDLE,
		TGSP_ARMED,
		TGSP_CAPTURE
	} tgsp_state_e;

	typedef struct packed {
		logic tmr_on;
		logic polarity;
		logic single_pulse;
		logic toggle;
		logic gate_en;
	} tgsp_ctrl_s;

	typedef struct packed {
		logic [`TGSP_ADDR_W-1:0] addr;
		logic [`TGSP_DATA_W-1:0] wdata;
		logic                    wr;
		logic                    rd;
	} tgsp_bus_s;
endpackage

// >>> core/tgsp_edge.sv
// Purpose: Registered gate level with rising and falling edge pulses
// Assumes: Gate input synchronous to clock_in
// Notes:   Edges are of the polarity-adjusted gate
`timescale 1ns/10ps
`default_nettype none
module tgsp_edge (
	input  wire logic clock_in,
	input  wire logic sys_rst_in,
	input  wire logic gate_in,
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);
	logic level_reg;
	logic level_next;

	always_comb begin
		level_next = gate_in;
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			// Reset polarity inverts an idle-low gate, so the adjusted idle level is high;
			// starting there avoids a false rise right after reset
			level_reg <= 1'b1;
		end else begin
			level_reg <= level_next;
		end
	end

	assign level_out = level_reg;
	assign rise_out  = gate_in & ~level_reg;
	assign fall_out  = ~gate_in & level_reg;
endmodule // tgsp_edge
`default_nettype wire

// >>> core/tgsp_gate.sv
// Purpose: Gate control of a 16-bit timer with single-pulse and toggle gating
// Assumes: Gate source synchronous to clock_in; register port strobes one cycle
// Notes:   Counter increments on every clock while the effective gate allows it
//
// Overview of operation
// - Single-pulse only when its enable bit set
// - Counting starts at next incrementing gate edge
// - Trailing edge of captured pulse clears go
// - After done, gate events ignored until rearm
// - Clearing single-pulse enable clears go immediately
// - Toggle plus single-pulse measures full period
// - Readable gate level shows latest gate value
// - Gate level valid while gate disabled
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tgsp_map.svh"
module tgsp_gate #(
	parameter int COUNT_W = `TGSP_DATA_W
) (
	input  wire logic                    clock_in,
	input  wire logic                    sys_rst_in,
	input  wire logic                    gate_src_in,
	input  wire logic [`TGSP_ADDR_W-1:0] addr_in,
	input  wire logic [`TGSP_DATA_W-1:0] wdata_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [`TGSP_DATA_W-1:0] rdata_out,
	output logic                         irq_out,
	output logic                         count_en_out
);
	tgsp_pkg::tgsp_bus_s   bus;
	tgsp_pkg::tgsp_ctrl_s  ctrl_reg;
	tgsp_pkg::tgsp_ctrl_s  ctrl_next;
	tgsp_pkg::tgsp_state_e state_reg;
	tgsp_pkg::tgsp_state_e state_next;
	logic [COUNT_W-1:0]          count_reg;
	logic [COUNT_W-1:0]          count_next;
	logic                        tog_reg;
	logic                        tog_next;
	logic [`TGSP_IRQ_W-1:0]      stat_reg;
	logic [`TGSP_IRQ_W-1:0]      stat_next;
	logic [`TGSP_IRQ_W-1:0]      mask_reg;
	logic [`TGSP_IRQ_W-1:0]      mask_next;
	logic [`TGSP_DATA_W-1:0]     rdata_reg;
	logic [`TGSP_DATA_W-1:0]     rdata_next;
	logic                        irq_reg;
	logic                        cen_reg;
	logic                        cen_next;
	logic                        gate_adj;
	logic                        lvl;
	logic                        rise;
	logic                        fall;
	logic                        go_wr;
	logic                        ctrl_wr;
	logic                        base_gate;
	logic                        inc_edge;
	logic                        trail_edge;
	logic                        ev_done;
	logic                        ev_ovf;
	logic [`TGSP_IRQ_W-1:0]      events;

	assign bus.addr  = addr_in;
	assign bus.wdata = wdata_in;
	assign bus.wr    = wr_in;
	assign bus.rd    = rd_in;

	// Polarity applied before edge detection so the status level follows the active sense
	assign gate_adj = gate_src_in ^ ~ctrl_reg.polarity;

	tgsp_edge u_edge (
		.clock_in  (clock_in),
		.sys_rst_in(sys_rst_in),
		.gate_in   (gate_adj),
		.level_out (lvl),
		.rise_out  (rise),
		.fall_out  (fall)
	);

	assign ctrl_wr = bus.wr && (bus.addr == `TGSP_OFF_CTRL);
	assign go_wr   = ctrl_wr && bus.wdata[`TGSP_BIT_GO]
		&& bus.wdata[`TGSP_BIT_SPM];

	// In toggle mode the increment edge is a rise of the toggled gate
	assign inc_edge   = ctrl_reg.toggle ? (rise && !tog_reg) : rise;
	assign trail_edge = ctrl_reg.toggle ? (rise && tog_reg) : fall;

	always_comb begin
		tog_next = tog_reg;
		if (!ctrl_reg.toggle) begin
			tog_next = 1'b0;
		end else if (rise) begin
			tog_next = ~tog_reg;
		end
	end

	assign base_gate = ctrl_reg.toggle ? tog_next : gate_adj;

	always_comb begin
		state_next = state_reg;
		ev_done    = 1'b0;
		unique case (state_reg)
			tgsp_pkg::TGSP_IDLE: begin
				if (go_wr) begin
					state_next = tgsp_pkg::TGSP_ARMED;
				end
			end
			tgsp_pkg::TGSP_ARMED: begin
				if (inc_edge) begin
					state_next = tgsp_pkg::TGSP_CAPTURE;
				end
			end
			tgsp_pkg::TGSP_CAPTURE: begin
				if (trail_edge) begin
					state_next = tgsp_pkg::TGSP_IDLE;
					ev_done    = 1'b1;
				end
			end
		endcase
		if (ctrl_wr && !bus.wdata[`TGSP_BIT_SPM]) begin
			state_next = tgsp_pkg::TGSP_IDLE;
			ev_done    = 1'b0;
		end
	end

	always_comb begin
		ctrl_next = ctrl_reg;
		if (ctrl_wr) begin
			ctrl_next.gate_en      = bus.wdata[`TGSP_BIT_GATE_EN];
			ctrl_next.toggle       = bus.wdata[`TGSP_BIT_TOGGLE];
			ctrl_next.single_pulse = bus.wdata[`TGSP_BIT_SPM];
			ctrl_next.polarity     = bus.wdata[`TGSP_BIT_POL];
			ctrl_next.tmr_on       = bus.wdata[`TGSP_BIT_TMR_ON];
		end
	end

	// Counting permission; single pulse overrides ordinary gating
	always_comb begin
		if (!ctrl_reg.tmr_on) begin
			cen_next = 1'b0;
		end else if (!ctrl_reg.gate_en) begin
			cen_next = 1'b1;
		end else if (ctrl_reg.single_pulse) begin
			cen_next = (state_next == tgsp_pkg::TGSP_CAPTURE);
		end else begin
			cen_next = base_gate;
		end
	end

	always_comb begin
		count_next = count_reg;
		ev_ovf     = 1'b0;
		if (bus.wr && (bus.addr == `TGSP_OFF_COUNT)) begin
			count_next = bus.wdata[COUNT_W-1:0];
		end else if (cen_reg) begin
			count_next = count_reg + 1'b1;
			ev_ovf     = &count_reg;
		end
	end

	assign events = {ev_ovf, ev_done};

	// Set wins over the write-one-to-clear
	always_comb begin
		stat_next = stat_reg;
		mask_next = mask_reg;
		if (bus.wr && (bus.addr == `TGSP_OFF_IRQ_STAT)) begin
			stat_next = stat_reg & ~bus.wdata[`TGSP_IRQ_W-1:0];
		end
		if (bus.wr && (bus.addr == `TGSP_OFF_IRQ_MASK)) begin
			mask_next = bus.wdata[`TGSP_IRQ_W-1:0];
		end
		stat_next = stat_next | events;
	end

	always_comb begin
		rdata_next = '0;
		if (bus.rd) begin
			unique case (bus.addr)
				`TGSP_OFF_CTRL: begin
					rdata_next[`TGSP_BIT_GATE_EN] = ctrl_reg.gate_en;
					rdata_next[`TGSP_BIT_TOGGLE]  = ctrl_reg.toggle;
					rdata_next[`TGSP_BIT_SPM]     = ctrl_reg.single_pulse;
					rdata_next[`TGSP_BIT_GO]      = (state_reg != tgsp_pkg::TGSP_IDLE);
					rdata_next[`TGSP_BIT_POL]     = ctrl_reg.polarity;
					rdata_next[`TGSP_BIT_TMR_ON]  = ctrl_reg.tmr_on;
					rdata_next[`TGSP_BIT_LEVEL]   = lvl;
				end
				`TGSP_OFF_COUNT:    rdata_next[COUNT_W-1:0] = count_reg;
				`TGSP_OFF_IRQ_STAT: rdata_next[`TGSP_IRQ_W-1:0] = stat_reg;
				`TGSP_OFF_IRQ_MASK: rdata_next[`TGSP_IRQ_W-1:0] = mask_reg;
				default:            rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctrl_reg  <= '0;
			state_reg <= tgsp_pkg::TGSP_IDLE;
			count_reg <= '0;
			tog_reg   <= 1'b0;
			stat_reg  <= '0;
			mask_reg  <= '0;
			rdata_reg <= '0;
			irq_reg   <= 1'b0;
			cen_reg   <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			state_reg <= state_next;
			count_reg <= count_next;
			tog_reg   <= tog_next;
			stat_reg  <= stat_next;
			mask_reg  <= mask_next;
			rdata_reg <= rdata_next;
			irq_reg   <= |(stat_next & mask_next);
			cen_reg   <= cen_next;
		end
	end

	assign rdata_out    = rdata_reg;
	assign irq_out      = irq_reg;
	assign count_en_out = cen_reg;

	property p_spm_off_clears;
		@(posedge clock_in) disable iff (sys_rst_in)
		!ctrl_reg.single_pulse |-> state_reg == tgsp_pkg::TGSP_IDLE;
	endproperty
	a_spm_off_clears: assert property (p_spm_off_clears) else $error("go set without spm");

	property p_no_count_idle;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ctrl_reg.single_pulse && ctrl_reg.gate_en && state_reg == tgsp_pkg::TGSP_IDLE)
			|=> !cen_reg;
	endproperty
	a_no_count_idle: assert property (p_no_count_idle) else $error("count while done");

	property p_arm;
		@(posedge clock_in) disable iff (sys_rst_in)
		(go_wr && state_reg == tgsp_pkg::TGSP_IDLE) |=> state_reg == tgsp_pkg::TGSP_ARMED;
	endproperty
	a_arm: assert property (p_arm) else $error("go write did not arm");

	property p_start;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state_reg == tgsp_pkg::TGSP_ARMED && inc_edge && !ctrl_wr)
			|=> state_reg == tgsp_pkg::TGSP_CAPTURE;
	endproperty
	a_start: assert property (p_start) else $error("capture not started");

	property p_done;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state_reg == tgsp_pkg::TGSP_CAPTURE && trail_edge && !ctrl_wr)
			|=> state_reg == tgsp_pkg::TGSP_IDLE && stat_reg[`TGSP_BIT_EV_DONE];
	endproperty
	a_done: assert property (p_done) else $error("done not reported");

	property p_level;
		@(posedge clock_in) disable iff (sys_rst_in)
		!$past(sys_rst_in) |-> lvl == $past(gate_adj);
	endproperty
	a_level: assert property (p_level) else $error("level status stale");

	property p_toggle;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ctrl_reg.toggle && $past(ctrl_reg.toggle) && $past(rise)) |-> tog_reg != $past(tog_reg);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");

	property p_go_read;
		@(posedge clock_in) disable iff (sys_rst_in)
		(rd_in && addr_in == `TGSP_OFF_CTRL)
			|=> rdata_out[`TGSP_BIT_GO] == ($past(state_reg) != tgsp_pkg::TGSP_IDLE);
	endproperty
	a_go_read: assert property (p_go_read) else $error("go read wrong");

	property p_gate_plain;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ctrl_reg.tmr_on && ctrl_reg.gate_en && !ctrl_reg.single_pulse && !ctrl_reg.toggle)
			|=> cen_reg == $past(gate_adj);
	endproperty
	a_gate_plain: assert property (p_gate_plain) else $error("ordinary gating wrong");

	property p_count_start;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state_reg == tgsp_pkg::TGSP_ARMED && inc_edge && ctrl_reg.tmr_on && ctrl_reg.gate_en
			&& ctrl_reg.single_pulse && !ctrl_wr) |=> cen_reg;
	endproperty
	a_count_start: assert property (p_count_start) else $error("count not enabled");

	property p_stay_done;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state_reg == tgsp_pkg::TGSP_IDLE && !go_wr) |=> state_reg == tgsp_pkg::TGSP_IDLE;
	endproperty
	a_stay_done: assert property (p_stay_done) else $error("left done without go");

	property p_abort;
		@(posedge clock_in) disable iff (sys_rst_in)
		(ctrl_wr && !bus.wdata[`TGSP_BIT_SPM])
			|=> state_reg == tgsp_pkg::TGSP_IDLE && !ctrl_reg.single_pulse;
	endproperty
	a_abort: assert property (p_abort) else $error("abort did not clear go");

	// A full source period ends at the second rise, when the toggled gate is high
	property p_period;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state_reg == tgsp_pkg::TGSP_CAPTURE && ctrl_reg.toggle && rise && tog_reg && !ctrl_wr)
			|=> state_reg == tgsp_pkg::TGSP_IDLE;
	endproperty
	a_period: assert property (p_period) else $error("period capture not ended");

	property p_w1c;
		@(posedge clock_in) disable iff (sys_rst_in)
		(bus.wr && bus.addr == `TGSP_OFF_IRQ_STAT && bus.wdata[`TGSP_BIT_EV_DONE] && !ev_done)
			|=> !stat_reg[`TGSP_BIT_EV_DONE];
	endproperty
	a_w1c: assert property (p_w1c) else $error("done status not cleared");

	property p_ovf;
		@(posedge clock_in) disable iff (sys_rst_in)
		(cen_reg && (&count_reg) && !(bus.wr && bus.addr == `TGSP_OFF_COUNT))
			|=> stat_reg[`TGSP_BIT_EV_OVF];
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not reported");

	property p_irq;
		@(posedge clock_in) disable iff (sys_rst_in)
		irq_out == |(stat_reg & mask_reg);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

	c_capture: cover property (@(posedge clock_in) state_reg == tgsp_pkg::TGSP_CAPTURE
		##1 state_reg == tgsp_pkg::TGSP_IDLE);
	c_period: cover property (@(posedge clock_in) ctrl_reg.toggle && ev_done);
	c_abort: cover property (@(posedge clock_in) state_reg == tgsp_pkg::TGSP_ARMED
		##1 !ctrl_reg.single_pulse);
	c_ovf: cover property (@(posedge clock_in) ev_ovf && !ctrl_reg.gate_en);
	c_level_off: cover property (@(posedge clock_in) !ctrl_reg.gate_en && rise);
endmodule // tgsp_gate
`default_nettype wire

// >>> dv/tgsp_gate_src.sv
// Purpose: Gate source model driving a synchronous level
// Assumes: Pulses are launched just after a rising clock edge
// Notes:   Idles low between pulses
`timescale 1ns/10ps
`default_nettype none
module tgsp_gate_src (
	input  wire logic clock_in,
	output logic      gate_out
);
	initial gate_out = 1'b0;

	// Whole-cycle levels only, since the block assumes a synchronous gate
	task automatic pulse(input int hi, input int lo);
		gate_out <= 1'b1;
		repeat (hi) @(posedge clock_in);
		gate_out <= 1'b0;
		repeat (lo) @(posedge clock_in);
	endtask
endmodule // tgsp_gate_src
`default_nettype wire

// >>> dv/test_timer_gate_single_pulse.sv
// Purpose: Self-checking bench of the timer gate block
// Assumes: Gate source active high, so the polarity bit is set
// Notes:   Counter value is compared with a tally of count enables
`timescale 1ns/10ps
`default_nettype none
`include "tgsp_map.svh"
module test_timer_gate_single_pulse;
	localparam logic [15:0] SP = 16'h003d;
	logic                      clock_in   = 1'b0;
	logic                      sys_rst_in = 1'b1;
	logic                      gate_src;
	logic [`TGSP_ADDR_W-1:0]   addr_in    = 4'h0;
	logic [`TGSP_DATA_W-1:0]   wdata_in   = 16'h0000;
	logic                      wr_in      = 1'b0;
	logic                      rd_in      = 1'b0;
	logic [`TGSP_DATA_W-1:0]   rdata_out;
	logic                      irq_out;
	logic                      count_en_out;
	logic [`TGSP_DATA_W-1:0]   d;
	int                        fail_count = 0;
	int                        samples_checked = 0;
	int                        tally = 0;
	int                        t0;

	initial forever #25 clock_in = ~clock_in;

	tgsp_gate dut (
		.clock_in    (clock_in),
		.sys_rst_in  (sys_rst_in),
		.gate_src_in (gate_src),
		.addr_in     (addr_in),
		.wdata_in    (wdata_in),
		.wr_in       (wr_in),
		.rd_in       (rd_in),
		.rdata_out   (rdata_out),
		.irq_out     (irq_out),
		.count_en_out(count_en_out)
	);

	tgsp_gate_src src (
		.clock_in(clock_in),
		.gate_out(gate_src)
	);

	always @(posedge clock_in) begin
		if (count_en_out === 1'b1)
			tally <= tally + 1;
	end

	task automatic complete_run;
		$display("compared %0d mismatched %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask

	// Polls the go bit; a capture that never ends must not hang the run
	task automatic wait_idle;
		for (int i = 0; i < 20; i++) begin
			rd(`TGSP_OFF_CTRL);
			if (d[`TGSP_BIT_GO] === 1'b0)
				return;
		end
		fail_count++;
		$display("unexpected at %0t: go bit stuck", $time);
		complete_run();
	endtask

	task automatic pulse_count(input int hi, input int lo);
		t0 = tally;
		src.pulse(hi, lo);
		wait_idle();
	endtask

	initial begin
		#250000;
		fail_count++;
		$display("unexpected at %0t: run hung", $time);
		complete_run();
	end

	initial begin
		repeat (5) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		rd(`TGSP_OFF_CTRL);
		chk(d, `TGSP_CTRL_RST | 16'h0040);
		rd(`TGSP_OFF_COUNT);
		chk(d, `TGSP_COUNT_RST);
		rd(4'h9);
		chk(d, 16'h0000);
		wr(`TGSP_OFF_CTRL, 16'h0018);
		rd(`TGSP_OFF_CTRL);
		chk(d, 16'h0010);
		fork
			src.pulse(8, 2);
			begin
				repeat (4) @(posedge clock_in);
				rd(`TGSP_OFF_CTRL);
			end
		join
		chk(d, 16'h0050);
		rd(`TGSP_OFF_CTRL);
		chk(d, 16'h0010);
		wr(`TGSP_OFF_IRQ_MASK, 16'h0001);
		wr(`TGSP_OFF_CTRL, SP);
		rd(`TGSP_OFF_CTRL);
		chk(d, SP);
		pulse_count(6, 4);
		chk({15'h0000, (tally - t0 >= 4 && tally - t0 <= 7)}, 16'h0001);
		rd(`TGSP_OFF_COUNT);
		chk(d, 16'(tally - t0));
		chk({15'h0000, irq_out}, 16'h0001);
		rd(`TGSP_OFF_IRQ_STAT);
		chk(d, 16'h0001);
		t0 = tally;
		src.pulse(6, 4);
		chk(16'(tally - t0), 16'h0000);
		wr(`TGSP_OFF_IRQ_STAT, 16'h0001);
		rd(`TGSP_OFF_IRQ_STAT);
		chk({d[14:0], irq_out}, 16'h0000);
		wr(`TGSP_OFF_CTRL, SP);
		pulse_count(5, 3);
		chk({15'h0000, (tally - t0 >= 3)}, 16'h0001);
		wr(`TGSP_OFF_IRQ_STAT, 16'h0001);
		wr(`TGSP_OFF_CTRL, SP);
		wr(`TGSP_OFF_CTRL, 16'h0031);
		rd(`TGSP_OFF_CTRL);
		chk(d, 16'h0031);
		rd(`TGSP_OFF_IRQ_STAT);
		chk({d[14:0], irq_out}, 16'h0000);
		wr(`TGSP_OFF_CTRL, 16'h003f);
		t0 = tally;
		src.pulse(3, 3);
		src.pulse(3, 3);
		src.pulse(3, 3);
		wait_idle();
		chk({15'h0000, (tally - t0 >= 5 && tally - t0 <= 7)}, 16'h0001);
		wr(`TGSP_OFF_IRQ_MASK, 16'h0000);
		rd(`TGSP_OFF_IRQ_STAT);
		chk({d[14:0], irq_out}, 16'h0002);
		// Free counting with the gate off: two enabled cycles wrap the counter once
		wr(`TGSP_OFF_COUNT, 16'hfffe);
		wr(`TGSP_OFF_CTRL, 16'h0030);
		wr(`TGSP_OFF_CTRL, 16'h0010);
		rd(`TGSP_OFF_IRQ_STAT);
		chk(d, 16'h0003);
		rd(`TGSP_OFF_COUNT);
		chk(d, 16'h0000);
		complete_run();
	end
endmodule // test_timer_gate_single_pulse
`default_nettype wire
